//--- hdl/lcm_ctrl.sv
`timescale 1ns/1ps
module lcm_ctrl #(
  parameter int SETS = lcm_pkg::LCM_SETS_DEF,
  parameter bit SECURITY_EXT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Straps and power
  input wire logic reset_sweep_disable,
  input wire logic ram_power_domain,
  input wire logic core_power_domain,
  input wire logic ram_retention,
  // Control bits
  input wire logic data_cache_enable_bit,
  input wire logic instr_cache_enable_bit,
  input wire logic data_cache_active_bit,
  input wire logic instr_cache_active_bit,
  // Maintenance request (pipeline side)
  input wire logic maint_valid,
  input wire lcm_pkg::lcm_op_t maint_op,
  input wire logic maint_nonsecure,
  output logic maint_ack,
  output lcm_pkg::lcm_op_t maint_exec_op,
  output logic maint_exec_dcache,
  output logic maint_busy,
  input wire logic maint_done,
  // Barriers
  input wire logic data_sync_barrier,
  input wire logic data_memory_barrier,
  input wire logic instr_sync_barrier,
  input wire logic exception_pending,
  output logic barrier_stall,
  output logic barrier_order,
  output logic fetch_refresh,
  // Data and instruction access attributes
  input wire logic [1:0] region_shareability_field,
  input wire logic data_inner_cacheable,
  input wire logic instr_inner_cacheable,
  output logic data_lookup_en,
  output logic data_alloc_en,
  output logic data_cacheable,
  output logic instr_lookup_en,
  output logic instr_alloc_en,
  output logic instr_cacheable,
  // Sweep RAM port
  output logic sweep_busy,
  output logic sweep_wr,
  output logic [$clog2(SETS)-1:0] sweep_index,
  output logic [lcm_pkg::LCM_IC_WAYS-1:0] sweep_ic_way_we,
  output logic [lcm_pkg::LCM_DC_WAYS-1:0] sweep_dc_way_we
);
  localparam int IW = $clog2(SETS);
  localparam logic [IW-1:0] LAST_IDX = IW'(SETS - 1);
  localparam logic [IW-1:0] FIRST_IDX = '0;

  // Sweep counter wraps on a power of two only
  if (SETS < 2 || (SETS & (SETS - 1)) != 0)
  begin
    $error("SETS must be a power of two of at least 2");
  end

  typedef struct packed {
    lcm_pkg::lcm_state_t st;
    logic [IW-1:0] idx;
    logic [2:0] ram_sync;
    logic ram_lvl;
    logic [2:0] strap_sync;
    logic strap_lvl;
    logic core_q;
    logic boot;
    logic outstanding;
    lcm_pkg::lcm_op_t exec_op;
    logic exec_dc;
  } lcm_state_vec_t;

  lcm_state_vec_t s_q;
  lcm_state_vec_t s_d;
  logic ram_now;
  logic strap_now;
  logic ram_rise;
  logic trig;

  // Promote non-secure invalidates only with security present
  function automatic lcm_pkg::lcm_op_t promote(lcm_pkg::lcm_op_t op,
                                               logic ns);
    lcm_pkg::lcm_op_t r;
    r = op;
    if (ns && SECURITY_EXT)
    begin
      case (op)
        lcm_pkg::LCM_OP_INVAL_SW: r = lcm_pkg::LCM_OP_CLEAN_INVAL_SW;
        lcm_pkg::LCM_OP_INVAL_POC: r = lcm_pkg::LCM_OP_CLEAN_INVAL_POC;
        lcm_pkg::LCM_OP_INVAL_POU: r = lcm_pkg::LCM_OP_CLEAN_INVAL_POU;
        default: r = op;
      endcase
    end
    return r;
  endfunction

  // A pin level counts once the second and third stages agree
  function automatic logic agreed(logic [2:0] sync, logic lvl);
    return (sync[1] == sync[2]) ? sync[2] : lvl;
  endfunction

  // Lookups need an active cache and a finished sweep
  function automatic logic lookup_ok(logic active, logic busy);
    return active & ~busy;
  endfunction

  // Allocation needs lookup, the enable bit and a cacheable access
  function automatic logic alloc_ok(logic lookup, logic en, logic cache);
    return lookup & en & cache;
  endfunction

  assign ram_now = agreed(s_q.ram_sync, s_q.ram_lvl);
  assign strap_now = agreed(s_q.strap_sync, s_q.strap_lvl);
  // Retention keeps the RAMs powered, so it never counts as a rise
  assign ram_rise = ram_now & ~s_q.ram_lvl & ~ram_retention;
  // Strap gates only the first power-up after reset
  assign trig = ram_rise & (s_q.boot ? ~strap_now : s_q.core_q);

  always_comb
  begin
    s_d = s_q;
    s_d.ram_sync = {s_q.ram_sync[1:0], ram_power_domain};
    s_d.ram_lvl = ram_now;
    s_d.strap_sync = {s_q.strap_sync[1:0], reset_sweep_disable};
    s_d.strap_lvl = strap_now;
    s_d.core_q = core_power_domain;
    if (s_q.boot && ram_now)
      s_d.boot = 1'b0;
    case (s_q.st)
      lcm_pkg::LCM_ST_IDLE:
      begin
        if (trig)
        begin
          s_d.st = lcm_pkg::LCM_ST_SWEEP;
          s_d.idx = FIRST_IDX;
        end
      end
      lcm_pkg::LCM_ST_SWEEP:
      begin
        if (s_q.idx == LAST_IDX)
          s_d.st = lcm_pkg::LCM_ST_IDLE;
        else
          s_d.idx = s_q.idx + IW'(1);
      end
      default: s_d.st = lcm_pkg::LCM_ST_IDLE;
    endcase
    if (maint_ack)
    begin
      s_d.outstanding = 1'b1;
      s_d.exec_op = promote(maint_op, maint_nonsecure);
      s_d.exec_dc = maint_op != lcm_pkg::LCM_OP_NONE;
    end
    else if (maint_done)
      s_d.outstanding = 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q.st <= lcm_pkg::LCM_ST_IDLE;
      s_q.idx <= '0;
      s_q.ram_sync <= 3'h0;
      s_q.ram_lvl <= 1'b0;
      s_q.strap_sync <= 3'h0;
      s_q.strap_lvl <= 1'b0;
      s_q.core_q <= 1'b0;
      s_q.boot <= 1'b1;
      s_q.outstanding <= 1'b0;
      s_q.exec_op <= lcm_pkg::LCM_OP_NONE;
      s_q.exec_dc <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // Sweep writes all ways at once, independent of the pipeline
  assign sweep_busy = s_q.st == lcm_pkg::LCM_ST_SWEEP;
  assign sweep_wr = sweep_busy;
  assign sweep_index = s_q.idx;
  assign sweep_ic_way_we = {lcm_pkg::LCM_IC_WAYS{sweep_busy}};
  assign sweep_dc_way_we = {lcm_pkg::LCM_DC_WAYS{sweep_busy}};

  // Maintenance swallowed during sweep or with the data cache inactive
  assign maint_ack = maint_valid & ~s_q.outstanding;
  assign maint_exec_op = s_q.exec_op;
  assign maint_exec_dcache = s_q.outstanding & s_q.exec_dc
    & ~sweep_busy & data_cache_active_bit;
  assign maint_busy = s_q.outstanding;

  // Exception releases the stall only; sweep is untouched
  assign barrier_stall = data_sync_barrier & ~exception_pending
    & (sweep_busy | s_q.outstanding);
  assign barrier_order = (data_memory_barrier | data_sync_barrier)
    & s_q.outstanding;
  assign fetch_refresh = instr_sync_barrier & ~s_q.outstanding;

  // Shared data bypasses the cache; coherency is left to the system
  assign data_cacheable = data_inner_cacheable & ~sweep_busy
    & (region_shareability_field == lcm_pkg::LCM_SH_NON);
  assign data_lookup_en = lookup_ok(data_cache_active_bit,
    sweep_busy);
  assign data_alloc_en = alloc_ok(data_lookup_en, data_cache_enable_bit,
    data_cacheable);
  assign instr_cacheable = instr_inner_cacheable;
  assign instr_lookup_en = lookup_ok(instr_cache_active_bit,
    sweep_busy);
  assign instr_alloc_en = alloc_ok(instr_lookup_en, instr_cache_enable_bit,
    instr_cacheable);

  sequence sweep_first_s;
    sweep_busy && sweep_index == FIRST_IDX;
  endsequence

  sequence sweep_last_s;
    sweep_busy && sweep_index == LAST_IDX;
  endsequence

  sweep_step_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sweep_busy && sweep_index != LAST_IDX
    |=> sweep_index == $past(sweep_index) + IW'(1))
    else $error("sweep index did not advance");
  sweep_end_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sweep_last_s |=> !sweep_busy)
    else $error("sweep busy after last index");
  sweep_start_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !sweep_busy && trig |=> sweep_first_s)
    else $error("sweep did not start at index zero");
  sweep_ways_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sweep_busy |-> &sweep_dc_way_we && &sweep_ic_way_we)
    else $error("not all ways cleared");
  sweep_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sweep_wr == sweep_busy)
    else $error("sweep write strobe wrong");
  no_lookup_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sweep_busy |-> !data_lookup_en && !instr_lookup_en && !data_cacheable)
    else $error("lookup during sweep");
  maint_nop_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sweep_busy |-> !maint_exec_dcache && !data_alloc_en && !instr_alloc_en)
    else $error("cache touched during sweep");
  dsb_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    data_sync_barrier && sweep_busy && !exception_pending |-> barrier_stall)
    else $error("barrier not held during sweep");
  exc_break_a: assert property (
    @(posedge clk) disable iff (!rstn)
    exception_pending && sweep_busy && sweep_index != LAST_IDX
    |-> !barrier_stall ##1 sweep_busy)
    else $error("exception handling wrong");
  maint_wait_a: assert property (
    @(posedge clk) disable iff (!rstn)
    data_sync_barrier && maint_busy && !exception_pending |-> barrier_stall)
    else $error("barrier not held for maintenance");
  barrier_free_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !sweep_busy && !maint_busy |-> !barrier_stall)
    else $error("barrier held with nothing pending");
  one_take_a: assert property (
    @(posedge clk) disable iff (!rstn)
    maint_busy |-> !maint_ack)
    else $error("request taken while busy");
  dmb_order_a: assert property (
    @(posedge clk) disable iff (!rstn)
    data_memory_barrier && maint_busy |-> barrier_order)
    else $error("memory barrier order lost");
  isb_refresh_a: assert property (
    @(posedge clk) disable iff (!rstn)
    instr_sync_barrier && !maint_busy |-> fetch_refresh)
    else $error("fetch refresh missing");
  isb_early_a: assert property (
    @(posedge clk) disable iff (!rstn)
    maint_busy |-> !fetch_refresh)
    else $error("fetch refresh before completion");
  share_nc_a: assert property (
    @(posedge clk) disable iff (!rstn)
    region_shareability_field[1] |-> !data_cacheable && !data_alloc_en)
    else $error("shared data cached");
  share_non_a: assert property (
    @(posedge clk) disable iff (!rstn)
    region_shareability_field == lcm_pkg::LCM_SH_NON && !sweep_busy
    |-> data_cacheable == data_inner_cacheable)
    else $error("non-shared attribute not followed");
  instr_attr_a: assert property (
    @(posedge clk) disable iff (!rstn)
    instr_cacheable == instr_inner_cacheable)
    else $error("instruction attribute changed");
  inactive_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !data_cache_active_bit |-> !data_lookup_en && !maint_exec_dcache)
    else $error("inactive cache accessed");
  inactive_i_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !instr_cache_active_bit |-> !instr_lookup_en && !instr_alloc_en)
    else $error("inactive instruction cache accessed");
  promote_a: assert property (
    @(posedge clk) disable iff (!rstn)
    maint_ack && maint_nonsecure && SECURITY_EXT
    && maint_op == lcm_pkg::LCM_OP_INVAL_SW
    |=> maint_exec_op == lcm_pkg::LCM_OP_CLEAN_INVAL_SW)
    else $error("invalidate not promoted");
  promote_poc_a: assert property (
    @(posedge clk) disable iff (!rstn)
    maint_ack && maint_nonsecure && SECURITY_EXT
    && maint_op == lcm_pkg::LCM_OP_INVAL_POC
    |=> maint_exec_op == lcm_pkg::LCM_OP_CLEAN_INVAL_POC)
    else $error("coherency invalidate not promoted");
  promote_pou_a: assert property (
    @(posedge clk) disable iff (!rstn)
    maint_ack && maint_nonsecure && SECURITY_EXT
    && maint_op == lcm_pkg::LCM_OP_INVAL_POU
    |=> maint_exec_op == lcm_pkg::LCM_OP_CLEAN_INVAL_POU)
    else $error("unification invalidate not promoted");
  no_promote_a: assert property (
    @(posedge clk) disable iff (!rstn)
    maint_ack && (!maint_nonsecure || !SECURITY_EXT)
    |=> maint_exec_op == $past(maint_op))
    else $error("operation changed without promotion");
  no_alloc_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !data_cache_enable_bit && data_cache_active_bit && !sweep_busy
    |-> data_lookup_en && !data_alloc_en)
    else $error("allocation while disabled");
  normal_op_a: assert property (
    @(posedge clk) disable iff (!rstn)
    data_cache_enable_bit && data_cache_active_bit && data_cacheable
    |-> data_lookup_en && data_alloc_en)
    else $error("normal allocation blocked");
  retention_a: assert property (
    @(posedge clk) disable iff (!rstn)
    ram_retention && !sweep_busy |=> !sweep_busy)
    else $error("retention started a sweep");
  strap_skip_a: assert property (
    @(posedge clk) disable iff (!rstn)
    s_q.boot && strap_now |-> !trig)
    else $error("reset sweep not skipped");
endmodule

//--- hdl/lcm_pkg.sv
package lcm_pkg;
  // Maintenance operation codes
  typedef enum logic [2:0] {
    LCM_OP_NONE,
    LCM_OP_INVAL_SW,
    LCM_OP_CLEAN_INVAL_SW,
    LCM_OP_INVAL_POC,
    LCM_OP_CLEAN_INVAL_POC,
    LCM_OP_INVAL_POU,
    LCM_OP_CLEAN_INVAL_POU,
    LCM_OP_CLEAN_SW
  } lcm_op_t;

  typedef enum logic [1:0] {
    LCM_ST_IDLE,
    LCM_ST_SWEEP
  } lcm_state_t;

  // Shareability encodings
  localparam logic [1:0] LCM_SH_NON = 2'h0;
  localparam logic [1:0] LCM_SH_OUTER = 2'h2;
  localparam logic [1:0] LCM_SH_INNER = 2'h3;

  localparam int LCM_IC_WAYS = 2;
  localparam int LCM_DC_WAYS = 4;
  localparam int LCM_SETS_DEF = 256;
endpackage

//--- bench/lcm_far_model.sv
`timescale 1ns/1ps
module lcm_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Maintenance handshake
  input wire logic maint_busy,
  input wire logic slow,
  output logic maint_done
);
  logic [2:0] cnt_q;
  // One-cycle done pulse; guard stops a second pulse before busy clears
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 3'h0;
      maint_done <= 1'b0;
    end
    else
    begin
      maint_done <= 1'b0;
      if (maint_busy && !maint_done)
      begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == (slow ? 3'h3 : 3'h0))
        begin
          maint_done <= 1'b1;
          cnt_q <= 3'h0;
        end
      end
    end
  end
endmodule

//--- bench/l1_cache_maintenance_control_tb_top.sv
`timescale 1ns/1ps
module l1_cache_maintenance_control_tb_top;
  localparam int SETS = 8;
  logic clk = 1'b0;
  logic rstn, reset_sweep_disable, ram_power_domain, core_power_domain;
  logic ram_retention, data_cache_enable_bit, instr_cache_enable_bit;
  logic data_cache_active_bit, instr_cache_active_bit, maint_valid;
  logic maint_nonsecure, maint_ack, maint_exec_dcache, maint_busy;
  logic maint_done, data_sync_barrier, data_memory_barrier;
  logic instr_sync_barrier, exception_pending, barrier_stall, barrier_order;
  logic fetch_refresh, data_inner_cacheable, instr_inner_cacheable;
  logic data_lookup_en, data_alloc_en, data_cacheable, instr_lookup_en;
  logic instr_alloc_en, instr_cacheable, sweep_busy, sweep_wr, slow;
  logic [1:0] region_shareability_field;
  logic [2:0] sweep_index;
  logic [1:0] sweep_ic_way_we;
  logic [3:0] sweep_dc_way_we;
  lcm_pkg::lcm_op_t maint_op, maint_exec_op, o, e;
  int n_mismatch = 0;
  int total_checks = 0;
  // In: shareability, cacheable d/i, enable, active
  // Out: data lookup, alloc, cacheable; instr lookup, alloc, cacheable
  logic [11:0] rows [9] = '{12'h3ff, 12'hbe7, 12'hfe7, 12'h0e4, 12'h864,
    12'h880, 12'h800, 12'h36d, 12'h389};

  lcm_ctrl #(.SETS(SETS)) i_dut (.*);
  lcm_far_model i_far (.clk(clk), .rstn(rstn), .maint_busy(maint_busy),
    .slow(slow), .maint_done(maint_done));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait on sweep_busy (0) or maint_busy (1)
  task automatic wait_on(input int w, input logic v);
    for (int i = 0; i < 20 && (w ? maint_busy : sweep_busy) !== v; i++)
      tick();
    if ((w ? maint_busy : sweep_busy) !== v)
    begin
      chk(12'h0, 12'h1);
      complete_run();
    end
  endtask

  initial
  begin
    {rstn, reset_sweep_disable, ram_power_domain, ram_retention, slow} = '0;
    {data_cache_enable_bit, instr_cache_enable_bit, maint_valid} = '0;
    {data_cache_active_bit, instr_cache_active_bit, maint_nonsecure} = 3'b110;
    {data_sync_barrier, data_memory_barrier, instr_sync_barrier} = '0;
    {exception_pending, data_inner_cacheable, instr_inner_cacheable} = '0;
    region_shareability_field = 2'h0;
    maint_op = lcm_pkg::LCM_OP_NONE;
    core_power_domain = 1'b1;
    tick(4);
    rstn <= 1'b1;
    tick();
    chk({sweep_busy, maint_busy, maint_exec_op}, 12'h0);
    @(posedge clk);
    ram_power_domain <= 1'b1;
    data_sync_barrier <= 1'b1;
    wait_on(0, 1'b1);
    maint_valid <= 1'b1;
    maint_op <= lcm_pkg::LCM_OP_INVAL_SW;
    for (int k = 0; k < SETS; k++)
    begin
      #1;
      chk({sweep_index, sweep_wr, sweep_ic_way_we, sweep_dc_way_we},
        {k[2:0], 7'h7f});
      chk({data_lookup_en, instr_lookup_en, maint_exec_dcache}, 12'h0);
      if (k < 3)
        chk(barrier_stall, 1'b1);
      exception_pending <= (k >= 3);
      @(posedge clk);
    end
    #1 chk(sweep_busy, 1'b0);
    {maint_valid, exception_pending} <= 2'b00;
    wait_on(1, 1'b0);
    instr_sync_barrier <= 1'b1;
    // Each code but LCM_OP_NONE in both security states; completion is fast or slow per code, alternating from one code to the next
    for (int n = 0; n < 14; n++)
    begin
      o = lcm_pkg::lcm_op_t'(n / 2 + 1);
      e = (n[0] && o inside {lcm_pkg::LCM_OP_INVAL_SW, lcm_pkg::LCM_OP_INVAL_POC,
        lcm_pkg::LCM_OP_INVAL_POU}) ? lcm_pkg::lcm_op_t'(o + 1) : o;
      @(posedge clk);
      {maint_valid, maint_nonsecure, slow} <= {1'b1, n[0], n[1]};
      maint_op <= o;
      #1 chk(maint_ack, 1'b1);
      @(posedge clk);
      maint_valid <= 1'b0;
      #1 chk({maint_busy, barrier_stall, barrier_order, maint_exec_dcache,
        fetch_refresh, maint_exec_op}, {5'h1e, e});
      wait_on(1, 1'b0);
    end
    chk({fetch_refresh, barrier_order}, 2'b10);
    {data_sync_barrier, instr_sync_barrier} <= 2'b00;
    foreach (rows[r])
    begin
      @(posedge clk);
      {region_shareability_field, data_inner_cacheable, instr_inner_cacheable,
        data_cache_enable_bit, data_cache_active_bit} <= rows[r][11:6];
      {instr_cache_enable_bit, instr_cache_active_bit} <= rows[r][7:6];
      #1 chk({data_lookup_en, data_alloc_en, data_cacheable, instr_lookup_en,
        instr_alloc_en, instr_cacheable},
        rows[r][5:0]);
    end
    @(posedge clk);
    ram_power_domain <= 1'b0;
    tick(4);
    ram_power_domain <= 1'b1;
    wait_on(0, 1'b1);
    wait_on(0, 1'b0);
    ram_retention <= 1'b1;
    ram_power_domain <= 1'b0;
    tick(4);
    ram_power_domain <= 1'b1;
    tick(10);
    chk(sweep_busy, 1'b0);
    @(posedge clk);
    {ram_retention, reset_sweep_disable, rstn} <= 3'b010;
    tick(4);
    rstn <= 1'b1;
    tick(10);
    chk(sweep_busy, 1'b0);
    complete_run();
  end
endmodule
